// ### bench/cmd_host_model.sv
/*
  host that issues single-byte command writes and reads.
  assumes one request at a time; idle lines are scrambled.
*/
`timescale 1ns/1ps
`default_nettype none
module cmd_host_model (
  input wire logic clock,
  output logic [7:0] cmd_code = 8'h00,
  output logic cmd_wr = 1'b0,
  output logic [7:0] cmd_wr_data = 8'h00,
  output logic cmd_rd = 1'b0,
  input wire logic [7:0] cmd_rd_data,
  input wire logic cmd_rd_valid
);
  // one write byte, taken at the next edge
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(posedge clock);
    #1;
    cmd_code = code;
    cmd_wr_data = data;
    cmd_wr = 1'b1;
    @(posedge clock);
    #1;
    cmd_wr = 1'b0;
    cmd_code = ~code;
    cmd_wr_data = ~data;
  endtask : wr
  // one read byte, data taken at the edge showing valid
  task automatic rd(input logic [7:0] code, output logic [7:0] data);
    data = 8'hxx;
    @(posedge clock);
    #1;
    cmd_code = code;
    cmd_rd = 1'b1;
    @(posedge clock);
    #1;
    cmd_rd = 1'b0;
    cmd_code = ~code;
    // valid stands for the cycle after the taking edge, so look once it has settled
    for (int i = 0; i < 4; i++) begin
      if (cmd_rd_valid === 1'b1) begin
        data = cmd_rd_data;
        break;
      end
      @(posedge clock);
      #1;
    end
  endtask : rd
endmodule : cmd_host_model
`default_nettype wire

// ### bench/thermal_fault_regs_chk.sv
/*
  port checker for the thermal and turn-on delay register bank.
  assumes the bench runs TICK_CYCLES small and drives enable as a level.
*/
`timescale 1ns/1ps
`default_nettype none
module thermal_fault_regs_chk #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_rd_data,
  input wire logic cmd_rd_valid,
  input wire logic [7:0] die_temperature,
  input wire logic [7:0] power_stage_input_voltage,
  input wire logic enable,
  input wire logic switching_on,
  input wire logic overtemp_fault_flag,
  input wire logic input_overvoltage_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  logic [15:0] en_run_ff;
  wire logic mapped = cmd_code inside {8'h4f, 8'h50, 8'h51, 8'h55, 8'h60, 8'h7c, 8'h7d};
  // counts cycles that enable has been high, saturating
  always_ff @(posedge clock) begin
    if (srst || !enable) en_run_ff <= 16'h0000;
    else if (en_run_ff != 16'hffff) en_run_ff <= en_run_ff + 16'h0001;
  end
  a_read_answer: assert property (cmd_rd |=> cmd_rd_valid) else $error("read not answered");
  a_data_hold: assert property (!cmd_rd |=> $stable(cmd_rd_data)) else $error("read data moved");
  a_unmapped_zero: assert property (cmd_rd && !mapped |=> cmd_rd_data == 8'h00) else $error("unmapped not zero");
  a_ov_flag_set: assert property (power_stage_input_voltage >= 8'hb9 |=> input_overvoltage_flag)
    else $error("overvoltage flag missing");
  a_ot_flag_set: assert property (die_temperature >= 8'h96 |=> overtemp_fault_flag)
    else $error("overtemp flag missing");
  a_ov_stops: assert property (power_stage_input_voltage >= 8'hb9 |-> ##2 !switching_on)
    else $error("switching after overvoltage");
  a_enable_off: assert property (!enable |-> ##2 !switching_on) else $error("switching while disabled");
  a_fault_sticky: assert property (overtemp_fault_flag && !(cmd_wr && cmd_code == 8'h7d) |=> overtemp_fault_flag)
    else $error("fault flag dropped");
  a_ton_wait: assert property ($rose(switching_on) |-> 32'(en_run_ff) > TICK_CYCLES)
    else $error("start without delay");
  c_start: cover property ($rose(switching_on));
  c_ot: cover property ($rose(overtemp_fault_flag));
  c_ov: cover property ($rose(input_overvoltage_flag));
endmodule : thermal_fault_regs_chk
bind thermal_fault_regs thermal_fault_regs_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clock(clock), .srst(srst),
  .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rd_data(cmd_rd_data), .cmd_rd_valid(cmd_rd_valid),
  .die_temperature(die_temperature), .power_stage_input_voltage(power_stage_input_voltage), .enable(enable),
  .switching_on(switching_on), .overtemp_fault_flag(overtemp_fault_flag),
  .input_overvoltage_flag(input_overvoltage_flag));
`default_nettype wire

// ### bench/thermal_fault_regs_tb.sv
/*
  self-checking bench for the thermal register bank.
  assumes TICK_CYCLES of 4, so a delay code c lasts (c+1)*4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module thermal_fault_regs_tb;
  localparam int T = 4;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic enable = 1'b0;
  logic [7:0] temp = 8'h19;
  logic [7:0] vin = 8'h78;
  logic [7:0] nvm [6];
  logic [7:0] d;
  logic [7:0] e;
  logic [7:0] regs [6] = '{8'h4f, 8'h50, 8'h51, 8'h55, 8'h60, 8'h33};
  logic [7:0] msk [6] = '{8'h07, 8'h08, 8'h07, 8'h01, 8'h03, 8'h00};
  logic [7:0] thr_reg [3] = '{8'h51, 8'h4f, 8'h55};
  wire logic [7:0] code, wdat, rdat;
  wire logic wr, rd, vld, sw, otf, otw, ovf;
  int err_count = 0;
  int n_compared = 0;
  int n;
  always #20 clock = ~clock;
  cmd_host_model host (.clock(clock), .cmd_code(code), .cmd_wr(wr), .cmd_wr_data(wdat), .cmd_rd(rd),
    .cmd_rd_data(rdat), .cmd_rd_valid(vld));
  thermal_fault_regs #(.TICK_CYCLES(T)) DUT (.clock(clock), .srst(srst), .cmd_code(code), .cmd_wr(wr),
    .cmd_wr_data(wdat), .cmd_rd(rd), .cmd_rd_data(rdat), .cmd_rd_valid(vld), .nvm_fault_limit(nvm[0]),
    .nvm_fault_action(nvm[1]), .nvm_warn_thresh(nvm[2]), .nvm_vin_ov(nvm[3]), .nvm_turn_on_delay_select(nvm[4]),
    .die_temperature(temp), .power_stage_input_voltage(vin), .enable(enable), .switching_on(sw),
    .overtemp_fault_flag(otf), .overtemp_warning_flag(otw), .input_overvoltage_flag(ovf));
  // warning threshold per code; code 5 gets a probe value only
  function automatic logic [7:0] warn_t(input int c);
    logic [7:0] tbl [8] = '{8'h55, 8'h5f, 8'h64, 8'h69, 8'h73, 8'h8c, 8'h7d, 8'h87};
    return tbl[c];
  endfunction : warn_t
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : tick
  // raise enable, count edges until switching starts
  task automatic run_up(output int m);
    enable = 1'b1;
    m = 0;
    while (sw !== 1'b1 && m < 2000) begin
      tick(1);
      m++;
    end
    if (m >= 2000) begin
      err_count++;
      print_verdict();
    end
  endtask : run_up
  // level just below then at threshold t, status bit polled
  task automatic thr(input int k, input logic [7:0] c, input logic [7:0] t, input logic hit);
    logic [7:0] st;
    logic [7:0] b;
    st = (k == 2) ? 8'h7c : 8'h7d;
    b = 8'h20 << k;
    host.wr(thr_reg[k], c);
    if (k == 2) vin = 8'h00;
    else temp = 8'h00;
    tick(2);
    if (k == 2) vin = t - 8'h01;
    else temp = t - 8'h01;
    tick(2);
    host.wr(st, 8'he0);
    tick(2);
    host.rd(st, d);
    check(d & b, 8'h00);
    check((k == 0) ? otw : (k == 1) ? otf : ovf, 1'b0);
    if (k == 2) vin = t;
    else temp = t;
    tick(2);
    host.rd(st, d);
    check(d & b, hit ? b : 8'h00);
    check((k == 0) ? otw : (k == 1) ? otf : ovf, hit);
  endtask : thr
  initial begin
    void'($urandom(32'h44a30af6));
    foreach (nvm[i]) nvm[i] = 8'($urandom);
    tick(8);
    srst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      host.rd(regs[i], d);
      check(d, nvm[i] & msk[i]);
      e = 8'($urandom);
      host.wr(regs[i], e);
      host.rd(regs[i], d);
      check(d, e & msk[i]);
    end
    $display("test defaults and masks done");
    for (int c = 0; c < 8; c++) thr(0, 8'(c), warn_t(c), c != 5);
    for (int c = 0; c < 8; c++) thr(1, 8'(c), 8'(115 + 5 * c), 1'b1);
    thr(2, 8'h00, 8'ha5, 1'b1);
    thr(2, 8'h01, 8'hb9, 1'b1);
    $display("test thresholds done");
    temp = 8'h19;
    vin = 8'h78;
    for (int c = 0; c < 4; c++) begin
      enable = 1'b0;
      host.wr(8'h60, 8'(c));
      run_up(n);
      check(n, (c + 1) * T + 1);
    end
    vin = 8'hb9;
    tick(3);
    check(sw, 1'b0);
    vin = 8'h87;
    enable = 1'b0;
    tick(2);
    enable = 1'b1;
    tick(30);
    check(sw, 1'b0);
    vin = 8'h86;
    enable = 1'b0;
    tick(2);
    run_up(n);
    check(n, 4 * T + 1);
    $display("test delay and overvoltage done");
    host.wr(8'h50, 8'h00);
    host.wr(8'h4f, 8'h00);
    temp = 8'h73;
    tick(3);
    temp = 8'h19;
    tick(600);
    check(sw, 1'b0);
    host.rd(8'h7d, d);
    check(d & 8'h40, 8'h40);
    enable = 1'b0;
    tick(2);
    run_up(n);
    check(n, 4 * T + 1);
    host.wr(8'h50, 8'h08);
    for (int r = 0; r < 2; r++) begin
      temp = 8'h73;
      tick(3);
      check(sw, 1'b0);
      temp = 8'h19;
      run_up(n);
      check(n, (112 + 4) * T - 2);
    end
    $display("test overtemp responses done");
    print_verdict();
  end
endmodule : thermal_fault_regs_tb
`default_nettype wire

// ### src/thermal_fault_defs.svh
/*
  command codes, field positions, thresholds and timing counts of the
  thermal, input and turn-on delay register bank.
  assumes a 25 MHz clock and byte-wide command accesses.
*/
`ifndef THERMAL_FAULT_DEFS_SVH
`define THERMAL_FAULT_DEFS_SVH

// command codes
`define CMD_OT_FAULT_LIMIT 8'h4f
`define CMD_OT_FAULT_ACTION 8'h50
`define CMD_OT_WARN_THRESH 8'h51
`define CMD_VIN_OV_THRESH 8'h55
`define CMD_TURN_ON_DELAY_SELECT_SEL 8'h60
`define CMD_STATUS_INPUT 8'h7c
`define CMD_STATUS_TEMP 8'h7d

// field positions and writable masks
`define RESTART_BIT 3
`define MASK_FAULT_LIMIT 8'h07
`define MASK_FAULT_ACTION 8'h08
`define MASK_WARN_THRESH 8'h07
`define MASK_VIN_OV 8'h01
`define MASK_TURN_ON_DELAY_SELECT 8'h03
`define STAT_TEMP_FAULT_BIT 6
`define STAT_TEMP_WARN_BIT 5
`define STAT_INPUT_OV_BIT 7

// thresholds: temperature in degrees C, voltage in 0.1 V steps
`define OV_RISE_LOW 8'ha5
`define OV_RISE_HIGH 8'hb9
`define OV_FALL 8'h87
`define WARN_UNDEFINED 8'hff

// timing: one tick is 0.5 ms
`define CLOCK_KHZ 25000
`define TICK_US 500
`define TICK_CYCLES ((`TICK_US * `CLOCK_KHZ) / 1000)
`define RESTART_MS 56
`define RESTART_TICKS 8'h70
`define TICK_CNT_W 16
`define TON_CNT_W 8

`endif

// ### src/thermal_fault_pkg.sv
/*
  types shared by the thermal, input and turn-on delay register bank.
  assumes nothing of its surroundings.
*/
`default_nettype none
package thermal_fault_pkg;
  // power sequencer states
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_TON_WAIT = 3'b001,
    ST_RUN = 3'b010,
    ST_OT_LATCH = 3'b011,
    ST_OT_RETRY = 3'b100,
    ST_OV_LATCH = 3'b101
  } seq_state_t;
endpackage : thermal_fault_pkg
`default_nettype wire

// ### src/thermal_fault_regs.sv
/*
  register bank and fault response for overtemperature, input overvoltage
  and turn-on delay, with a small power-on sequencer.
  assumes a byte command port fed by a serial-bus front end, telemetry
  synchronous to clock, and nonvolatile defaults stable during srst.
*/
`include "thermal_fault_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module thermal_fault_regs #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_wr_data,
  input wire logic cmd_rd,
  output logic [7:0] cmd_rd_data,
  output logic cmd_rd_valid,
  input wire logic [7:0] nvm_fault_limit,
  input wire logic [7:0] nvm_fault_action,
  input wire logic [7:0] nvm_warn_thresh,
  input wire logic [7:0] nvm_vin_ov,
  input wire logic [7:0] nvm_turn_on_delay_select,
  input wire logic [7:0] die_temperature,
  input wire logic [7:0] power_stage_input_voltage,
  input wire logic enable,
  output logic switching_on,
  output logic overtemp_fault_flag,
  output logic overtemp_warning_flag,
  output logic input_overvoltage_flag
);

  // warning code to threshold, 101b never triggers
  function automatic logic [7:0] warn_deg(input logic [2:0] code);
    unique case (code)
      3'b000: warn_deg = 8'h55;
      3'b001: warn_deg = 8'h5f;
      3'b010: warn_deg = 8'h64;
      3'b011: warn_deg = 8'h69;
      3'b100: warn_deg = 8'h73;
      3'b101: warn_deg = `WARN_UNDEFINED;
      3'b110: warn_deg = 8'h7d;
      3'b111: warn_deg = 8'h87;
    endcase
  endfunction : warn_deg

  // fault code to threshold, 115 C plus 5 C per step
  function automatic logic [7:0] fault_deg(input logic [2:0] code);
    fault_deg = 8'h73 + {3'h0, code, 2'h0} + {5'h00, code};
  endfunction : fault_deg

  logic [7:0] fault_limit_ff;
  logic [7:0] fault_action_ff;
  logic [7:0] warn_thresh_ff;
  logic [7:0] vin_ov_ff;
  logic [7:0] turn_on_delay_select_ff;
  logic [7:0] cmd_rd_data_ff;
  logic cmd_rd_valid_ff;
  logic ot_flag_ff;
  logic warn_flag_ff;
  logic ov_flag_ff;
  logic ov_active_ff;
  logic switching_ff;
  thermal_fault_pkg::seq_state_t state_ff;
  thermal_fault_pkg::seq_state_t nxt_state;
  logic [`TICK_CNT_W-1:0] tick_cnt_ff;
  logic [`TON_CNT_W-1:0] wait_cnt_ff;
  logic [`TON_CNT_W-1:0] nxt_wait_cnt;

  // command decode
  wire wr_fault_limit = cmd_wr && (cmd_code == `CMD_OT_FAULT_LIMIT);
  wire wr_fault_action = cmd_wr && (cmd_code == `CMD_OT_FAULT_ACTION);
  wire wr_warn_thresh = cmd_wr && (cmd_code == `CMD_OT_WARN_THRESH);
  wire wr_vin_ov = cmd_wr && (cmd_code == `CMD_VIN_OV_THRESH);
  wire wr_turn_on_delay_select = cmd_wr && (cmd_code == `CMD_TURN_ON_DELAY_SELECT_SEL);
  wire wr_stat_temp = cmd_wr && (cmd_code == `CMD_STATUS_TEMP);
  wire wr_stat_input = cmd_wr && (cmd_code == `CMD_STATUS_INPUT);

  // digital comparators against live register values
  wire ot_fault_now = die_temperature >= fault_deg(fault_limit_ff[2:0]);
  wire ot_warn_now = (warn_thresh_ff[2:0] != 3'b101) &&
                     (die_temperature >= warn_deg(warn_thresh_ff[2:0]));
  wire [7:0] ov_rise = vin_ov_ff[0] ? `OV_RISE_HIGH : `OV_RISE_LOW;
  wire ov_rise_hit = power_stage_input_voltage >= ov_rise;
  wire ov_fall_hit = power_stage_input_voltage < `OV_FALL;

  // start qualifiers and timers
  wire start_ok = enable && !ov_active_ff && !ot_fault_now;
  wire tick = tick_cnt_ff == `TICK_CNT_W'(TICK_CYCLES - 1);
  wire [`TON_CNT_W-1:0] ton_ticks = {6'h00, turn_on_delay_select_ff[1:0]} + `TON_CNT_W'(1);
  wire timer_done = tick && (wait_cnt_ff == `TON_CNT_W'(1));
  wire state_change = nxt_state != state_ff;

  // read mux, unused bits masked to zero
  wire [7:0] stat_temp = {1'b0, ot_flag_ff, warn_flag_ff, 5'h00};
  wire [7:0] stat_input = {ov_flag_ff, 7'h00};
  wire [7:0] rd_mux =
    (cmd_code == `CMD_OT_FAULT_LIMIT) ? fault_limit_ff :
    (cmd_code == `CMD_OT_FAULT_ACTION) ? fault_action_ff :
    (cmd_code == `CMD_OT_WARN_THRESH) ? warn_thresh_ff :
    (cmd_code == `CMD_VIN_OV_THRESH) ? vin_ov_ff :
    (cmd_code == `CMD_TURN_ON_DELAY_SELECT_SEL) ? turn_on_delay_select_ff :
    (cmd_code == `CMD_STATUS_TEMP) ? stat_temp :
    (cmd_code == `CMD_STATUS_INPUT) ? stat_input : 8'h00;

  // configuration registers: defaults from nvm, live host writes
  always_ff @(posedge clock) begin
    if (srst) begin
      fault_limit_ff <= nvm_fault_limit & `MASK_FAULT_LIMIT;
      fault_action_ff <= nvm_fault_action & `MASK_FAULT_ACTION;
      warn_thresh_ff <= nvm_warn_thresh & `MASK_WARN_THRESH;
      vin_ov_ff <= nvm_vin_ov & `MASK_VIN_OV;
      turn_on_delay_select_ff <= nvm_turn_on_delay_select & `MASK_TURN_ON_DELAY_SELECT;
    end else begin
      if (wr_fault_limit) fault_limit_ff <= cmd_wr_data & `MASK_FAULT_LIMIT;
      if (wr_fault_action) fault_action_ff <= cmd_wr_data & `MASK_FAULT_ACTION;
      if (wr_warn_thresh) warn_thresh_ff <= cmd_wr_data & `MASK_WARN_THRESH;
      if (wr_vin_ov) vin_ov_ff <= cmd_wr_data & `MASK_VIN_OV;
      if (wr_turn_on_delay_select) turn_on_delay_select_ff <= cmd_wr_data & `MASK_TURN_ON_DELAY_SELECT;
    end
  end

  // single-byte read answer one cycle after the request
  always_ff @(posedge clock) begin
    if (srst) begin
      cmd_rd_data_ff <= 8'h00;
      cmd_rd_valid_ff <= 1'b0;
    end else begin
      cmd_rd_valid_ff <= cmd_rd;
      if (cmd_rd) cmd_rd_data_ff <= rd_mux;
    end
  end

  // sticky flags, write one to clear, a new event wins over the clear
  always_ff @(posedge clock) begin
    if (srst) begin
      ot_flag_ff <= 1'b0;
      warn_flag_ff <= 1'b0;
      ov_flag_ff <= 1'b0;
    end else begin
      ot_flag_ff <= ot_fault_now ||
        (ot_flag_ff && !(wr_stat_temp && cmd_wr_data[`STAT_TEMP_FAULT_BIT]));
      warn_flag_ff <= ot_warn_now ||
        (warn_flag_ff && !(wr_stat_temp && cmd_wr_data[`STAT_TEMP_WARN_BIT]));
      ov_flag_ff <= ov_rise_hit ||
        (ov_flag_ff && !(wr_stat_input && cmd_wr_data[`STAT_INPUT_OV_BIT]));
    end
  end

  // overvoltage detector with hysteresis
  always_ff @(posedge clock) begin
    if (srst) ov_active_ff <= 1'b0;
    else if (ov_rise_hit) ov_active_ff <= 1'b1;
    else if (ov_fall_hit) ov_active_ff <= 1'b0;
  end

  // sequencer next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      thermal_fault_pkg::ST_OFF: begin
        if (start_ok) nxt_state = thermal_fault_pkg::ST_TON_WAIT;
      end
      thermal_fault_pkg::ST_TON_WAIT, thermal_fault_pkg::ST_RUN: begin
        if (ov_rise_hit) nxt_state = thermal_fault_pkg::ST_OV_LATCH;
        else if (ot_fault_now) nxt_state = fault_action_ff[`RESTART_BIT] ?
          thermal_fault_pkg::ST_OT_RETRY : thermal_fault_pkg::ST_OT_LATCH;
        else if (!enable) nxt_state = thermal_fault_pkg::ST_OFF;
        else if (state_ff == thermal_fault_pkg::ST_TON_WAIT && timer_done)
          nxt_state = thermal_fault_pkg::ST_RUN;
      end
      thermal_fault_pkg::ST_OT_LATCH, thermal_fault_pkg::ST_OV_LATCH: begin
        if (!enable) nxt_state = thermal_fault_pkg::ST_OFF;
      end
      thermal_fault_pkg::ST_OT_RETRY: begin
        if (!enable) nxt_state = thermal_fault_pkg::ST_OFF;
        else if (timer_done) nxt_state = thermal_fault_pkg::ST_TON_WAIT;
      end
      default: nxt_state = thermal_fault_pkg::ST_OFF;
    endcase
  end

  // tick count loaded on entry to a timed state
  always_comb begin
    nxt_wait_cnt = wait_cnt_ff;
    if (state_change && nxt_state == thermal_fault_pkg::ST_TON_WAIT) nxt_wait_cnt = ton_ticks;
    else if (state_change && nxt_state == thermal_fault_pkg::ST_OT_RETRY) nxt_wait_cnt = `RESTART_TICKS;
    else if (tick && wait_cnt_ff != `TON_CNT_W'(0)) nxt_wait_cnt = wait_cnt_ff - `TON_CNT_W'(1);
  end

  // half-millisecond divider, restarted on every state change
  always_ff @(posedge clock) begin
    if (srst || state_change || tick) tick_cnt_ff <= '0;
    else tick_cnt_ff <= tick_cnt_ff + `TICK_CNT_W'(1);
  end

  // sequencer registers
  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= thermal_fault_pkg::ST_OFF;
      wait_cnt_ff <= '0;
      switching_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wait_cnt_ff <= nxt_wait_cnt;
      switching_ff <= nxt_state == thermal_fault_pkg::ST_RUN;
    end
  end

  assign cmd_rd_data = cmd_rd_data_ff;
  assign cmd_rd_valid = cmd_rd_valid_ff;
  assign switching_on = switching_ff;
  assign overtemp_fault_flag = ot_flag_ff;
  assign overtemp_warning_flag = warn_flag_ff;
  assign input_overvoltage_flag = ov_flag_ff;

endmodule : thermal_fault_regs
`default_nettype wire
